// ---- hdl/pmt_divider.sv ----
`timescale 1ns/10ps
// Tick divider: pulses out every (last+1) input ticks
module pmt_divider
    import pmt_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         sys_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         clear_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] last_i,
    output logic              tick_o
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        tick_o     = 1'b0;
        if (clear_i)
        begin
            next_count = '0;
        end
        else if (tick_i)
        begin
            if (count >= last_i)
            begin
                next_count = '0;
                tick_o     = 1'b1;
            end
            else
            begin
                next_count = count + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count <= '0;
        else
            count <= next_count;
    end

endmodule : pmt_divider

// ---- hdl/pmt_timer.sv ----
`timescale 1ns/10ps
// Operation
// RULE_01 - Postscaler divides matches by select plus one
// RULE_02 - Timer counts only while run bit set
// RULE_03 - Control field layout; resets to zero
// RULE_04 - Control bit seven reads zero, ignores writes
// RULE_05 - Period register resets to all ones
// RULE_06 - Count wraps to zero after period match
// RULE_07 - Postscaler output sets match interrupt flag
// RULE_08 - Prescaler fed by instruction clock, osc/4
// RULE_09 - Count/control writes clear both scalers
// RULE_10 - Prescale select 00=1, 01=4, 1x=16
module pmt_timer
    import pmt_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    output logic                   match_o,
    output logic                   irq_o
);

    // ************************************************************
    // State
    // ************************************************************
    pmt_bus_t   bus;
    logic [7:0] control;
    logic [7:0] period;
    logic [7:0] count;
    logic [7:0] irq_en;
    logic [7:0] irq_flag;
    logic [7:0] rdata;
    logic [1:0] instr_div;
    logic       match_q;
    logic [7:0] next_control;
    logic [7:0] next_period;
    logic [7:0] next_count;
    logic [7:0] next_irq_en;
    logic [7:0] next_irq_flag;
    logic [7:0] next_rdata;
    logic [1:0] next_instr_div;
    logic       instr_tick;
    logic       pre_tick;
    logic       post_tick;
    logic       scaler_clear;
    logic       count_tick;
    logic       at_period;
    logic [3:0] pre_last;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ************************************************************
    // Scalers
    // ************************************************************
    assign instr_tick   = (instr_div == INSTR_LAST);             // RULE_08
    assign scaler_clear = bus.wr && (bus.addr == ADDR_CONTROL    // RULE_09
                          || bus.addr == ADDR_COUNT);

    always_comb
    begin
        if (control[PRE_LSB+1])                                  // RULE_10
            pre_last = PRE_LAST_DIV16;
        else if (control[PRE_LSB+:PRE_W] == PRE_SEL_DIV4)
            pre_last = PRE_LAST_DIV4;
        else
            pre_last = PRE_LAST_DIV1;
    end

    pmt_divider #(.W(4)) u_pre
    (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .clear_i   (scaler_clear),
        .tick_i    (instr_tick && control[RUN_BIT]),            // RULE_02
        .last_i    (pre_last),
        .tick_o    (pre_tick)
    );

    assign count_tick = pre_tick;
    assign at_period  = (count == period);

    pmt_divider #(.W(POST_W)) u_post
    (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .clear_i   (scaler_clear),
        .tick_i    (count_tick && at_period),                   // RULE_06
        .last_i    (control[POST_LSB+:POST_W]),                 // RULE_01
        .tick_o    (post_tick)
    );

    // ************************************************************
    // Registers and bus
    // ************************************************************
    always_comb
    begin
        next_control   = control;
        next_period    = period;
        next_count     = count;
        next_irq_en    = irq_en;
        next_irq_flag  = irq_flag;
        next_rdata     = 8'h00;
        next_instr_div = instr_div + 2'h1;
        if (count_tick)
        begin
            if (at_period)
                next_count = COUNT_RESET;                        // RULE_06
            else
                next_count = count + 8'h01;
        end
        if (bus.wr)
        begin
            if (bus.addr == ADDR_CONTROL)
                next_control = bus.wdata & CONTROL_MASK;         // RULE_04
            else if (bus.addr == ADDR_PERIOD)
                next_period = bus.wdata;
            else if (bus.addr == ADDR_COUNT)
                next_count = bus.wdata;
            else if (bus.addr == ADDR_IRQ_EN)
                next_irq_en = bus.wdata & IRQ_MASK;
            else if (bus.addr == ADDR_IRQ_FLAG)
                next_irq_flag = irq_flag & ~bus.wdata;
        end
        if (post_tick)
            next_irq_flag[MATCH_IRQ_BIT] = 1'b1;                 // RULE_07
        if (bus.rd)
        begin
            if (bus.addr == ADDR_CONTROL)
                next_rdata = control & CONTROL_MASK;             // RULE_04
            else if (bus.addr == ADDR_PERIOD)
                next_rdata = period;
            else if (bus.addr == ADDR_COUNT)
                next_rdata = count;
            else if (bus.addr == ADDR_IRQ_EN)
                next_rdata = irq_en;
            else if (bus.addr == ADDR_IRQ_FLAG)
                next_rdata = irq_flag;
            else
                next_rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            control   <= CONTROL_RESET;                          // RULE_03
            period    <= PERIOD_RESET;                           // RULE_05
            count     <= COUNT_RESET;                            // RULE_06
            irq_en    <= IRQ_RESET;
            irq_flag  <= IRQ_RESET;
            rdata     <= 8'h00;
            instr_div <= 2'h0;
            match_q   <= 1'b0;
        end
        else
        begin
            control   <= next_control;
            period    <= next_period;
            count     <= next_count;
            irq_en    <= next_irq_en;
            irq_flag  <= next_irq_flag;
            rdata     <= next_rdata;
            instr_div <= next_instr_div;
            match_q   <= count_tick && at_period;
        end
    end

    assign rdata_o = rdata;
    assign match_o = match_q;
    assign irq_o   = |(irq_flag & irq_en);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Period hit that no bus write overrides
    sequence period_hit_s;
        count_tick && at_period && !bus.wr;
    endsequence

    ctrl_top_zero_a: assert property (control[7] == 1'b0) // RULE_04
        else $error("control bit 7 set");
    stop_holds_a: assert property ( // RULE_02
        (!control[RUN_BIT] && !bus.wr) |=> $stable(count))
        else $error("count moved while stopped");
    wrap_zero_a: assert property ( // RULE_06
        period_hit_s |=> count == 8'h00)
        else $error("count did not wrap");
    count_step_a: assert property ( // RULE_08
        (count_tick && !at_period && !bus.wr)
        |=> count == $past(count) + 8'h01)
        else $error("count did not step");
    flag_set_a: assert property ( // RULE_07
        post_tick |=> irq_flag[MATCH_IRQ_BIT])
        else $error("match flag not set");
    post_one_a: assert property ( // RULE_01
        (control[POST_LSB+:POST_W] == 4'h0 && count_tick && at_period
        && !bus.wr) |-> post_tick)
        else $error("1:1 postscale missed");
    pre_div1_a: assert property ( // RULE_10
        (control[PRE_LSB+:PRE_W] == PRE_SEL_DIV1 && control[RUN_BIT]
        && instr_tick && !bus.wr) |-> pre_tick)
        else $error("divide by one missed");
    scaler_clr_a: assert property ( // RULE_09
        (bus.wr && bus.addr == ADDR_CONTROL)
        |=> $stable(count) || $past(count_tick))
        else $error("control write touched count");
    ctrl_read_a: assert property ( // RULE_03
        (bus.rd && bus.addr == ADDR_CONTROL)
        |=> rdata_o == $past(control))
        else $error("control readback wrong");
    match_out_a: assert property ( // RULE_06
        period_hit_s |=> match_o)
        else $error("match pulse missing");
    rdata_idle_a: assert property (!bus.rd |=> rdata_o == 8'h00)
        else $error("read data left standing");
    // Clear only checked when no set collides, since set wins
    flag_clear_a: assert property ( // RULE_07
        (bus.wr && bus.addr == ADDR_IRQ_FLAG
        && bus.wdata[MATCH_IRQ_BIT] && !post_tick)
        |=> !irq_flag[MATCH_IRQ_BIT])
        else $error("match flag not cleared");
    en_mask_a: assert property ((irq_en & ~IRQ_MASK) == 8'h00)
        else $error("unused enable bit set");

endmodule : pmt_timer

// ---- shared/pmt_pkg.sv ----
package pmt_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int           ADDR_W         = 3;
    localparam logic [2:0]   ADDR_CONTROL   = 3'h0;
    localparam logic [2:0]   ADDR_PERIOD    = 3'h1;
    localparam logic [2:0]   ADDR_COUNT     = 3'h2;
    localparam logic [2:0]   ADDR_IRQ_EN    = 3'h3;
    localparam logic [2:0]   ADDR_IRQ_FLAG  = 3'h4;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int           POST_LSB       = 3;
    localparam int           POST_W         = 4;
    localparam int           RUN_BIT        = 2;
    localparam int           PRE_LSB        = 0;
    localparam int           PRE_W          = 2;
    localparam logic [7:0]   CONTROL_MASK   = 8'h7F;
    localparam logic [7:0]   CONTROL_RESET  = 8'h00;
    localparam logic [7:0]   PERIOD_RESET   = 8'hFF;
    localparam logic [7:0]   COUNT_RESET    = 8'h00;
    localparam int           MATCH_IRQ_BIT  = 1;
    localparam logic [7:0]   IRQ_MASK       = 8'h02;
    localparam logic [7:0]   IRQ_RESET      = 8'h00;

    // ************************************************************
    // Prescaler
    // ************************************************************
    localparam logic [1:0]   PRE_SEL_DIV1   = 2'h0;
    localparam logic [1:0]   PRE_SEL_DIV4   = 2'h1;
    localparam logic [3:0]   PRE_LAST_DIV1  = 4'h0;
    localparam logic [3:0]   PRE_LAST_DIV4  = 4'h3;
    localparam logic [3:0]   PRE_LAST_DIV16 = 4'hF;
    localparam int           INSTR_DIV      = 4;
    localparam logic [1:0]   INSTR_LAST     = 2'(INSTR_DIV - 1);

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } pmt_bus_t;

endpackage : pmt_pkg

// ---- tb/pmt_tb.sv ----
`timescale 1ns/10ps
module tb;
    import pmt_pkg::*;

    // ****************************************
    // Clock, reset and design
    // ****************************************
    logic              sys_clk_i  = 1'b0;
    logic              reset_n_i  = 1'b0;
    logic [ADDR_W-1:0] addr_i     = '0;
    logic [7:0]        wdata_i    = 8'h00;
    logic              wr_i       = 1'b0;
    logic              rd_i       = 1'b0;
    logic [7:0]        rdata_o;
    logic              match_o;
    logic              irq_o;
    int                num_errors = 0;
    int                n_compared = 0;
    int                posts[4]   = '{0, 1, 9, 15};

    always #2.5 sys_clk_i = ~sys_clk_i;

    pmt_timer u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .match_o(match_o), .irq_o(irq_o));

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic give_up;
        num_errors++;
        $display("[FAIL] wait expected event seen timeout");
        test_done();
    endtask : give_up

    // Idle cycle after each strobe so no edge assigns it twice
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
        @(posedge sys_clk_i);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp,
                          input string what);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        @(negedge sys_clk_i);
        check(what, 16'(rdata_o), 16'(exp));
        @(posedge sys_clk_i);
    endtask : reg_rd

    // Irq looked at mid-cycle, away from the edge that moves it
    task automatic check_irq(input logic exp, input string what);
        @(negedge sys_clk_i);
        check(what, 16'(irq_o), 16'(exp));
        @(posedge sys_clk_i);
    endtask : check_irq

    task automatic wait_match(output int n);
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
            if (n > 3000)
                give_up();
        end
        while (match_o !== 1'b1);
    endtask : wait_match

    // Steady gap between two pulses, so the start phase does not matter
    task automatic match_gap(input logic [1:0] pre, input int exp);
        int t;
        int gap;
        reg_wr(ADDR_CONTROL, {5'h00, 1'b1, pre});
        wait_match(t);
        wait_match(gap);
        check("match gap", 16'(gap), 16'(exp));
        @(posedge sys_clk_i);
    endtask : match_gap

    // Matches counted between two fresh irq rises; a stale flag is
    // cleared first, so both ends sit on a real postscaler output
    task automatic post_check(input int n);
        int rises;
        int cnt;
        bit prev;
        bit go;
        rises = 0;
        cnt   = 0;
        prev  = 1'b1;
        go    = 1'b0;
        reg_wr(ADDR_CONTROL, 8'((n << POST_LSB) | (1 << RUN_BIT)));
        for (int t = 0; t < 3000 && rises < 2; t++)
        begin
            @(negedge sys_clk_i);
            if (rises == 1 && match_o === 1'b1)
                cnt++;
            if (irq_o === 1'b1 && prev == 1'b0)
                rises++;
            prev = (irq_o === 1'b1);
            go   = prev && (rises < 2);
            @(posedge sys_clk_i);
            addr_i  <= ADDR_IRQ_FLAG;
            wdata_i <= IRQ_MASK;
            wr_i    <= go;
        end
        @(posedge sys_clk_i);
        check("irq rises", 16'(rises), 16'h0002);
        check("post ratio", 16'(cnt), 16'(n + 1));
    endtask : post_check

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd(ADDR_CONTROL, 8'h00, "control reset");
        reg_rd(ADDR_PERIOD, 8'hFF, "period reset");
        reg_rd(ADDR_COUNT, 8'h00, "count reset");
        reg_rd(ADDR_IRQ_EN, 8'h00, "enable reset");
        reg_rd(ADDR_IRQ_FLAG, 8'h00, "flag reset");
        reg_wr(ADDR_CONTROL, 8'hFB);
        reg_rd(ADDR_CONTROL, 8'h7B, "control top bit");
        reg_rd(3'h5, 8'h00, "unmapped read");
        $display("test registers done");
        reg_wr(ADDR_COUNT, 8'h42);
        repeat (100) @(posedge sys_clk_i);
        reg_rd(ADDR_COUNT, 8'h42, "count stopped");
        reg_wr(ADDR_CONTROL, 8'h78);
        reg_rd(ADDR_COUNT, 8'h42, "count kept");
        reg_wr(ADDR_CONTROL, 8'h06);
        repeat (200) @(posedge sys_clk_i);
        reg_wr(ADDR_COUNT, 8'h10);
        repeat (30) @(posedge sys_clk_i);
        reg_rd(ADDR_COUNT, 8'h10, "prescale cleared");
        repeat (60) @(posedge sys_clk_i);
        reg_rd(ADDR_COUNT, 8'h11, "one prescale");
        $display("test run and clear done");
        reg_wr(ADDR_PERIOD, 8'h03);
        match_gap(2'h0, 16);
        match_gap(2'h1, 64);
        match_gap(2'h2, 256);
        match_gap(2'h3, 256);
        $display("test prescale done");
        reg_wr(ADDR_IRQ_EN, 8'hFF);
        reg_rd(ADDR_IRQ_EN, 8'h02, "enable bits");
        foreach (posts[i])
            post_check(posts[i]);
        $display("test postscale done");
        reg_wr(ADDR_CONTROL, 8'h00);
        reg_wr(ADDR_IRQ_EN, 8'h00);
        check_irq(1'b0, "irq masked");
        reg_rd(ADDR_IRQ_FLAG, 8'h02, "flag sticky");
        reg_wr(ADDR_IRQ_EN, 8'h02);
        check_irq(1'b1, "irq unmasked");
        reg_wr(ADDR_IRQ_FLAG, 8'h02);
        reg_rd(ADDR_IRQ_FLAG, 8'h00, "flag cleared");
        check_irq(1'b0, "irq cleared");
        $display("test interrupt done");
        reg_wr(ADDR_PERIOD, 8'h20);
        reg_wr(ADDR_CONTROL, 8'h05);
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd(ADDR_CONTROL, 8'h00, "control rerun");
        reg_rd(ADDR_PERIOD, 8'hFF, "period rerun");
        reg_rd(ADDR_COUNT, 8'h00, "count rerun");
        $display("test reset done");
        test_done();
    end
endmodule : tb
